/* hw/csa_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CSA_CFG_SVH
`define CSA_CFG_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define CSA_IDX_CONFIG 8'h90
`define CSA_IDX_START 8'h92
`define CSA_IDX_END 8'h93
`define CSA_IDX_RESULT 8'h94
`define CSA_IDX_THRESH 8'h95
`define CSA_IDX_STATUS 8'h96
`define CSA_IDX_CLEAR 8'h97
`define CSA_IDX_ENABLE 8'h98
`define CSA_IDX_CHANNEL 8'h9c

// ==========================================================
// field positions
`define CSA_CFG_ACC_LSB 0
`define CSA_CFG_ACC_MSB 2
`define CSA_CFG_SCAN_BIT 3
`define CSA_CHAN_MSB 5
`define CSA_EV_DONE_BIT 0
`define CSA_EV_GT_BIT 1

// ==========================================================
// reset values
`define CSA_RST_CONFIG 4'h0
`define CSA_RST_CHAN 6'h00
`define CSA_RST_RESULT 16'h0000
`define CSA_RST_THRESH 16'h0000
`define CSA_RST_EVENTS 2'h0

// ==========================================================
// timing: edges from read request to read answer
`define CSA_READ_WAIT 1

`endif

/* hw/csa_pkg.sv */
// shared types of the capacitive-sense result logic
package csa_pkg;
	typedef enum logic [0:0] {
		CSA_BUS_IDLE = 1'b0,
		CSA_BUS_DONE = 1'b1
	} csa_bus_state_type;

	typedef logic [5:0] csa_chan_type;
	typedef logic [15:0] csa_word_type;
	typedef logic [2:0] csa_acc_sel_type;
	typedef logic [1:0] csa_events_type;
endpackage

/* hw/csa_accum.sv */
// sample accumulator and power-of-two divider
`timescale 1ns/1ns
`default_nettype none
`include "csa_cfg.svh"
module csa_accum #(
	parameter int SAMPLE_W = 16,
	parameter int MAX_LOG = 6
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// samples in
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	input wire csa_pkg::csa_acc_sel_type acc_sel,
	// result out
	output logic result_valid,
	output logic [SAMPLE_W-1:0] result
);
	import csa_pkg::*;

	if (SAMPLE_W != 16 || MAX_LOG != 6) begin : bad_params
		$error("csa_accum: only 16-bit samples and 64-sample depth are served");
	end

	// ==========================================================
	// shift for each accumulate setting
	// codes above 64x are taken as 64x
	function automatic logic [2:0] acc_shift(input csa_acc_sel_type sel);
		case (sel)
			3'h0: acc_shift = 3'h0;
			3'h1: acc_shift = 3'h2;
			3'h2: acc_shift = 3'h3;
			3'h3: acc_shift = 3'h4;
			3'h4: acc_shift = 3'h5;
			default: acc_shift = 3'h6;
		endcase
	endfunction

	// ==========================================================
	// accumulate
	logic [SAMPLE_W+MAX_LOG-1:0] sum;
	logic [SAMPLE_W+MAX_LOG-1:0] next_sum;
	logic [MAX_LOG:0] count;
	logic [MAX_LOG:0] next_count;
	logic next_result_valid;
	logic [SAMPLE_W-1:0] next_result;
	logic [SAMPLE_W+MAX_LOG-1:0] total;
	logic [MAX_LOG:0] target;

	always_comb begin
		total = sum + (SAMPLE_W+MAX_LOG)'(sample_data);
		target = (MAX_LOG+1)'(1) << acc_shift(acc_sel);
		next_sum = sum;
		next_count = count;
		next_result = result;
		next_result_valid = 1'b0;
		if (sample_valid) begin
			if (count + (MAX_LOG+1)'(1) >= target) begin
				next_result = SAMPLE_W'(total >> acc_shift(acc_sel));
				next_result_valid = 1'b1;
				next_sum = '0;
				next_count = '0;
			end else begin
				next_sum = total;
				next_count = count + (MAX_LOG+1)'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sum <= '0;
			count <= '0;
			result <= `CSA_RST_RESULT;
			result_valid <= 1'b0;
		end else if (ce) begin
			sum <= next_sum;
			count <= next_count;
			result <= next_result;
			result_valid <= next_result_valid;
		end
	end
endmodule
`default_nettype wire

/* hw/csa_scan.sv */
// auto-scan channel stepper
`timescale 1ns/1ns
`default_nettype none
`include "csa_cfg.svh"
module csa_scan (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// control
	input wire logic scan_on,
	input wire logic step,
	input wire logic above,
	input wire csa_pkg::csa_chan_type start_chan,
	input wire csa_pkg::csa_chan_type end_chan,
	// software writes
	input wire logic start_wr,
	input wire csa_pkg::csa_chan_type start_wdata,
	input wire logic chan_wr,
	input wire csa_pkg::csa_chan_type chan_wdata,
	// mux selection
	output csa_pkg::csa_chan_type channel
);
	import csa_pkg::*;

	csa_chan_type next_channel;

	// ==========================================================
	// step logic; software writes win over a step in the same cycle
	always_comb begin
		next_channel = channel;
		if (step && scan_on) begin
			if (above) begin
				next_channel = channel;
			end else if (channel == end_chan) begin
				next_channel = start_chan;
			end else begin
				next_channel = channel + 6'h01;
			end
		end
		if (chan_wr) begin
			next_channel = chan_wdata;
		end
		if (start_wr && scan_on) begin
			next_channel = start_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			channel <= `CSA_RST_CHAN;
		end else if (ce) begin
			channel <= next_channel;
		end
	end
endmodule
`default_nettype wire

/* hw/csa_top.sv */
// capacitive-sense result handling with auto-scan and register slave
`timescale 1ns/1ns
`default_nettype none
`include "csa_cfg.svh"

module csa_top #(
	parameter int SAMPLE_W = 16,
	parameter int ADDR_W = 10
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// conversion front end
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	output csa_pkg::csa_chan_type channel_select,
	// interrupt
	output logic irq
);
	import csa_pkg::*;

	if (SAMPLE_W != 16 || ADDR_W < 10) begin : bad_params
		$error("csa_top: needs 16-bit samples and at least 10 address bits");
	end

	// ==========================================================
	// address decode helpers
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		hit = (addr == ADDR_W'({idx, 2'b00}));
	endfunction

	function automatic logic [31:0] widen16(input csa_word_type value);
		widen16 = {16'h0000, value};
	endfunction

	// ==========================================================
	// register state
	logic [3:0] sense_config_register;
	logic [3:0] next_config;
	csa_chan_type scan_start_channel;
	csa_chan_type next_start;
	csa_chan_type scan_end_channel;
	csa_chan_type next_end;
	csa_word_type threshold;
	csa_word_type next_threshold;
	csa_events_type status;
	csa_events_type next_status;
	csa_events_type int_enable;
	csa_events_type next_int_enable;

	// ==========================================================
	// bus handshake state
	csa_bus_state_type bus_state;
	csa_bus_state_type next_bus_state;
	logic [31:0] next_readdata;
	logic wr_take;

	// ==========================================================
	// datapath wires
	csa_acc_sel_type accumulate_count_field;
	logic scan_on;
	logic result_valid;
	csa_word_type result;
	logic above;
	logic start_wr;
	logic chan_wr;

	assign accumulate_count_field = sense_config_register[`CSA_CFG_ACC_MSB:`CSA_CFG_ACC_LSB];
	assign scan_on = sense_config_register[`CSA_CFG_SCAN_BIT];

	assign above = (result > threshold);

	// writes wait only while ce is low; reads also wait one edge for registered data
	assign wr_take = write && ce;
	assign waitrequest = (read || write) && (!ce || (read && bus_state == CSA_BUS_IDLE));

	assign start_wr = wr_take && hit(address, `CSA_IDX_START);
	assign chan_wr = wr_take && hit(address, `CSA_IDX_CHANNEL);

	// ==========================================================
	// accumulator
	csa_accum #(
		.SAMPLE_W(SAMPLE_W),
		.MAX_LOG(6)
	) u_accum (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.sample_valid(sample_valid),
		.sample_data(sample_data),
		.acc_sel(accumulate_count_field),
		.result_valid(result_valid),
		.result(result)
	);

	// ==========================================================
	// channel stepper
	csa_scan u_scan (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.scan_on(scan_on),
		.step(result_valid),
		.above(above),
		.start_chan(scan_start_channel),
		.end_chan(scan_end_channel),
		.start_wr(start_wr),
		.start_wdata(writedata[`CSA_CHAN_MSB:0]),
		.chan_wr(chan_wr),
		.chan_wdata(writedata[`CSA_CHAN_MSB:0]),
		.channel(channel_select)
	);

	// ==========================================================
	// register writes and events
	always_comb begin
		next_config = sense_config_register;
		next_start = scan_start_channel;
		next_end = scan_end_channel;
		next_threshold = threshold;
		next_status = status;
		next_int_enable = int_enable;
		if (wr_take) begin
			if (hit(address, `CSA_IDX_CONFIG)) begin
				next_config = writedata[3:0];
			end else if (hit(address, `CSA_IDX_START)) begin
				next_start = writedata[`CSA_CHAN_MSB:0];
			end else if (hit(address, `CSA_IDX_END)) begin
				next_end = writedata[`CSA_CHAN_MSB:0];
			end else if (hit(address, `CSA_IDX_THRESH)) begin
				next_threshold = writedata[15:0];
			end else if (hit(address, `CSA_IDX_CLEAR)) begin
				next_status = status & ~writedata[1:0];
			end else if (hit(address, `CSA_IDX_ENABLE)) begin
				next_int_enable = writedata[1:0];
			end
		end
		// events set after the clear so a same-cycle event survives
		if (result_valid) begin
			next_status[`CSA_EV_DONE_BIT] = 1'b1;
			if (above) begin
				next_status[`CSA_EV_GT_BIT] = 1'b1;
				if (scan_on) begin
					next_config[`CSA_CFG_SCAN_BIT] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sense_config_register <= `CSA_RST_CONFIG;
			scan_start_channel <= `CSA_RST_CHAN;
			scan_end_channel <= `CSA_RST_CHAN;
			threshold <= `CSA_RST_THRESH;
			status <= `CSA_RST_EVENTS;
			int_enable <= `CSA_RST_EVENTS;
		end else if (ce) begin
			sense_config_register <= next_config;
			scan_start_channel <= next_start;
			scan_end_channel <= next_end;
			threshold <= next_threshold;
			status <= next_status;
			int_enable <= next_int_enable;
		end
	end

	// ==========================================================
	// read path; data registered so readdata comes from a flop
	always_comb begin
		next_bus_state = CSA_BUS_IDLE;
		next_readdata = readdata;
		if (read && bus_state == CSA_BUS_IDLE) begin
			next_bus_state = CSA_BUS_DONE;
			if (hit(address, `CSA_IDX_CONFIG)) begin
				next_readdata = {28'h0000000, sense_config_register};
			end else if (hit(address, `CSA_IDX_START)) begin
				next_readdata = {26'h0, scan_start_channel};
			end else if (hit(address, `CSA_IDX_END)) begin
				next_readdata = {26'h0, scan_end_channel};
			end else if (hit(address, `CSA_IDX_RESULT)) begin
				next_readdata = widen16(result);
			end else if (hit(address, `CSA_IDX_THRESH)) begin
				next_readdata = widen16(threshold);
			end else if (hit(address, `CSA_IDX_STATUS)) begin
				next_readdata = {30'h0, status};
			end else if (hit(address, `CSA_IDX_ENABLE)) begin
				next_readdata = {30'h0, int_enable};
			end else if (hit(address, `CSA_IDX_CHANNEL)) begin
				next_readdata = {26'h0, channel_select};
			end else begin
				// unmapped and write-only read as zero
				next_readdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_state <= CSA_BUS_IDLE;
			readdata <= 32'h00000000;
		end else if (ce) begin
			bus_state <= next_bus_state;
			readdata <= next_readdata;
		end
	end

	// ==========================================================
	// interrupt output
	assign irq = |(status & int_enable);
endmodule
`default_nettype wire

/* bench/csa_fe_model.sv */
// behavioural conversion front end: one sample pulse per request
`timescale 1ns/1ns
`default_nettype none
module csa_fe_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// request from the bench
	input wire logic fire,
	input wire logic [1:0] lat,
	input wire logic [15:0] value,
	// to the block
	output logic sample_valid,
	output logic [15:0] sample_data
);
	logic [1:0] wait_cnt;
	logic busy;
	logic [15:0] hold;
	// ==========================================
	// conversion timing
	// one pulse each
	always_ff @(posedge mclk) begin
		sample_valid <= 1'b0;
		// data is garbage outside the pulse, so a late sample is caught
		sample_data <= ~sample_data;
		if (rst) begin
			busy <= 1'b0;
			sample_data <= 16'h5a5a;
		end else if (fire) begin
			busy <= 1'b1;
			wait_cnt <= lat;
			hold <= value;
		end else if (busy && wait_cnt == 2'h0) begin
			busy <= 1'b0;
			sample_valid <= 1'b1;
			sample_data <= hold;
		end else if (busy) begin
			wait_cnt <= wait_cnt - 2'h1;
		end
	end
endmodule
`default_nettype wire

/* bench/csa_top_assertions.sv */
// port-level checks of the cap-sense result block
`timescale 1ns/1ns
`default_nettype none
module csa_top_assertions
	import csa_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// bus
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// front end and interrupt
	input wire logic sample_valid,
	input wire csa_pkg::csa_chan_type channel_select,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ==========================================
	// sequences
	sequence read_answer;
		waitrequest ##1 !waitrequest;
	endsequence
	// ==========================================
	// checks
	chk_reset_clear: assert property (
		$fell(rst) |-> channel_select == 6'h00 && !irq && readdata == 32'h0)
		else $error("state not cleared by reset");
	chk_write_nowait: assert property (
		write && ce |-> !waitrequest) else $error("write stalled");
	chk_read_wait: assert property (
		$rose(read) && ce |-> read_answer) else $error("read answer late");
	chk_idle_nowait: assert property (
		!read && !write |-> !waitrequest) else $error("wait without request");
	chk_wait_short: assert property (
		waitrequest && ce |=> !waitrequest) else $error("wait too long");
	chk_chan_cause: assert property (
		$changed(channel_select) |-> $past(write) || $past(sample_valid, 2))
		else $error("channel moved without cause");
	chk_irq_cause: assert property (
		$changed(irq) |-> $past(write) || $past(sample_valid, 2))
		else $error("irq moved without cause");
	chk_data_hold: assert property (
		$changed(readdata) |-> $past(read)) else $error("readdata moved");
endmodule
bind csa_top csa_top_assertions chk (.mclk(mclk), .rst(rst), .ce(ce), .read(read),
	.write(write), .readdata(readdata), .waitrequest(waitrequest),
	.sample_valid(sample_valid), .channel_select(channel_select), .irq(irq));
`default_nettype wire

/* bench/csa_top_tb.sv */
// self-checking bench for the cap-sense result block
`timescale 1ns/1ns
`default_nettype none
module csa_top_tb;
	import csa_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [9:0] address = 10'h000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic sample_valid;
	logic [15:0] sample_data;
	csa_chan_type channel_select;
	logic irq;
	logic fire = 1'b0;
	logic [1:0] lat = 2'h0;
	logic [15:0] value = 16'h0;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int mtab[6] = '{1, 4, 8, 16, 32, 64};
	int m;
	logic [15:0] a;
	logic [15:0] ex;
	always #5 mclk = ~mclk;
	csa_top dut (.mclk(mclk), .rst(rst), .ce(ce), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sample_valid(sample_valid),
		.sample_data(sample_data), .channel_select(channel_select), .irq(irq));
	csa_fe_model fe (.mclk(mclk), .rst(rst), .fire(fire), .lat(lat), .value(value),
		.sample_valid(sample_valid), .sample_data(sample_data));
	// ==========================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] v);
		@(posedge mclk);
		address <= {idx, 2'b00};
		writedata <= v;
		write <= 1'b1;
		@(posedge mclk);
		while (waitrequest) @(posedge mclk);
		write <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		@(posedge mclk);
		address <= {idx, 2'b00};
		read <= 1'b1;
		@(posedge mclk);
		while (waitrequest) @(posedge mclk);
		read <= 1'b0;
		chk(readdata, exp);
	endtask
	// latency varies per call so prompt and slow conversions both occur
	task automatic conv(input logic [15:0] v);
		@(posedge mclk);
		value <= v;
		lat <= lat + 2'h1;
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		@(posedge mclk);
		while (!sample_valid) @(posedge mclk);
		repeat (2) @(posedge mclk);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
	// ==========================================
	// tests
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		rdchk(8'h92, 32'h0);
		wr(8'h92, 32'hff);
		rdchk(8'h92, 32'h3f);
		wr(8'h93, 32'hc5);
		rdchk(8'h93, 32'h05);
		rdchk(8'h91, 32'h0);
		rdchk(8'h9c, 32'h0);
		wr(8'h98, 32'h3);
		$display("test registers done");
		for (int k = 0; k < 6; k++) begin
			m = mtab[k];
			a = 16'h0100 + 16'(k * 64);
			ex = (m == 1) ? a : a + 16'h11;
			wr(8'h90, 32'(k));
			wr(8'h95, {16'h0, ex});
			for (int i = 0; i < m; i++) begin
				if (i == m - 1) rdchk(8'h96, 32'h0);
				conv(i % 2 ? a + 16'h23 : a);
			end
			rdchk(8'h94, {16'h0, ex});
			rdchk(8'h96, 32'h1);
			chk(irq, 1'b1);
			wr(8'h97, 32'h3);
			rdchk(8'h96, 32'h0);
			chk(irq, 1'b0);
			chk(channel_select, 6'h00);
		end
		$display("test accumulate done");
		wr(8'h98, 32'h0);
		wr(8'h90, 32'h0);
		conv(ex + 16'h1);
		rdchk(8'h96, 32'h3);
		chk(irq, 1'b0);
		wr(8'h98, 32'h2);
		rdchk(8'h96, 32'h3);
		chk(irq, 1'b1);
		wr(8'h97, 32'h3);
		$display("test threshold done");
		wr(8'h95, 32'hffff);
		wr(8'h92, 32'h03);
		wr(8'h93, 32'h05);
		wr(8'h90, 32'h08);
		rdchk(8'h9c, 32'h0);
		wr(8'h92, 32'h03);
		rdchk(8'h9c, 32'h3);
		for (int j = 0; j < 3; j++) begin
			conv(16'h10);
			chk(channel_select, j == 2 ? 6'h03 : 6'(4 + j));
		end
		wr(8'h95, 32'h5);
		conv(16'h6);
		rdchk(8'h90, 32'h0);
		conv(16'h6);
		chk(channel_select, 6'h03);
		$display("test scan done");
		wr(8'h97, 32'h3);
		@(posedge mclk);
		ce <= 1'b0;
		conv(16'h7);
		ce <= 1'b1;
		rdchk(8'h96, 32'h0);
		chk(channel_select, 6'h03);
		$display("test clock enable done");
		end_of_test();
	end
endmodule
`default_nettype wire
